// ---- design/sec_pkg.sv ----
// Constants, types and carriers for the serial EEPROM command controller
package sec_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SK_HALF_NS    = 500;
  localparam int unsigned SK_HALF_CYC   = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMO_US        = 10000;
  localparam int unsigned TMO_CYC       = TMO_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned POLL_SETTLE_CYC = 4;

  localparam logic [7:0] CMD_OFS   = 8'hb0;
  localparam logic [7:0] DATA_OFS  = 8'hb4;
  localparam logic [7:0] STAT_OFS  = 8'hb8;
  localparam logic [7:0] MACLO_OFS = 8'hbc;
  localparam logic [7:0] MACHI_OFS = 8'hc0;

  localparam int unsigned BUSY_BIT  = 31;
  localparam int unsigned OP_LSB    = 28;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned FRAME_W   = 18;
  localparam int unsigned TMO_BIT   = 0;
  localparam int unsigned MACOK_BIT = 1;

  localparam logic        BUSY_RST  = 1'b1;
  localparam logic [6:0]  ADDR_RST  = 7'h00;
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic [7:0]  SIG_BYTE  = 8'ha5;
  localparam logic [2:0]  MAC_BYTES = 3'h6;

  typedef enum logic [2:0] {
    OP_READ   = 3'b000,
    OP_EWDS   = 3'b001,
    OP_EWEN   = 3'b010,
    OP_WRITE  = 3'b011,
    OP_WRAL   = 3'b100,
    OP_ERASE  = 3'b101,
    OP_ERAL   = 3'b110,
    OP_RELOAD = 3'b111
  } sec_op_e;

  typedef struct packed {
    logic [FRAME_W-1:0] tx;
    logic [4:0]         tx_len;
    logic [3:0]         rx_len;
    logic               poll;
  } sec_frame_s;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } sec_pins_s;
endpackage

// ---- design/sec_timer.sv ----
// Ready-poll timeout counter
module sec_timer #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // Control
  input  wire logic run_i,
  output logic      expired_o
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        exp_r;
  logic        exp_nxt;

  always_comb begin
    cnt_nxt = 32'h0;
    exp_nxt = 1'b0;
    if (run_i) begin
      cnt_nxt = (cnt_r == 32'(LIMIT - 1)) ? cnt_r : cnt_r + 32'h1;
      exp_nxt = (cnt_r == 32'(LIMIT - 1)) && !exp_r;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 32'h0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired_o = exp_r;
endmodule

// ---- design/sec_shift.sv ----
// Serial EEPROM frame shifter with ready polling
module sec_shift import sec_pkg::*; (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Request
  input  wire logic        start_i,
  input  sec_frame_s       frame_i,
  input  wire logic        abort_i,
  // Synchronised serial data from the EEPROM
  input  wire logic        do_i,
  // Results
  output sec_pins_s        pins_o,
  output logic             done_o,
  output logic             timeout_o,
  output logic             polling_o,
  output logic [7:0]       rx_o
);
  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_SHIFT = 2'b01,
    SH_GAP   = 2'b10,
    SH_POLL  = 2'b11
  } sec_sh_e;

  sec_sh_e            st_r, st_nxt;
  logic [7:0]         div_r, div_nxt;
  logic [4:0]         cnt_r, cnt_nxt;
  logic [FRAME_W-1:0] sh_r, sh_nxt;
  sec_frame_s         fr_r, fr_nxt;
  sec_pins_s          pins_r, pins_nxt;
  logic [7:0]         rx_r, rx_nxt;
  logic               done_r, done_nxt;
  logic               tmo_r, tmo_nxt;
  logic               tick;
  logic               settled;

  assign tick    = (div_r == 8'(SK_HALF_CYC - 1));
  assign settled = (div_r == 8'(POLL_SETTLE_CYC));

  always_comb begin
    st_nxt   = st_r;
    div_nxt  = 8'h00;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    fr_nxt   = fr_r;
    pins_nxt = pins_r;
    rx_nxt   = rx_r;
    done_nxt = 1'b0;
    tmo_nxt  = 1'b0;
    case (st_r)
      SH_IDLE: begin
        if (start_i) begin
          fr_nxt   = frame_i;
          sh_nxt   = frame_i.tx;
          cnt_nxt  = 5'h00;
          rx_nxt   = 8'h00;
          pins_nxt = '{cs: 1'b1, sk: 1'b0, di: frame_i.tx[FRAME_W-1]};
          st_nxt   = SH_SHIFT;
        end
      end
      SH_SHIFT: begin
        div_nxt = tick ? 8'h00 : div_r + 8'h01;
        if (tick && !pins_r.sk) begin
          // EEPROM takes DI on the rising edge; read bits are taken here too
          pins_nxt.sk = 1'b1;
          if (cnt_r >= fr_r.tx_len) begin
            rx_nxt = {rx_r[6:0], do_i};
          end
        end else if (tick) begin
          pins_nxt.sk = 1'b0;
          cnt_nxt     = cnt_r + 5'h01;
          sh_nxt      = {sh_r[FRAME_W-2:0], 1'b0};
          pins_nxt.di = sh_r[FRAME_W-2];
          if (cnt_r + 5'h01 == fr_r.tx_len + 5'(fr_r.rx_len)) begin
            pins_nxt.cs = 1'b0;
            pins_nxt.di = 1'b0;
            if (fr_r.poll) begin
              st_nxt = SH_GAP;
            end else begin
              done_nxt = 1'b1;
              st_nxt   = SH_IDLE;
            end
          end
        end
      end
      SH_GAP: begin
        // Chip select low for a half period starts the ready status output
        div_nxt = tick ? 8'h00 : div_r + 8'h01;
        if (tick) begin
          pins_nxt.cs = 1'b1;
          st_nxt      = SH_POLL;
        end
      end
      SH_POLL: begin
        // Synchronised DO still shows the released line for a few cycles after select
        div_nxt = settled ? div_r : div_r + 8'h01;
        if ((do_i && settled) || abort_i) begin
          pins_nxt.cs = 1'b0;
          done_nxt    = 1'b1;
          tmo_nxt     = !(do_i && settled);
          st_nxt      = SH_IDLE;
        end
      end
      default: st_nxt = SH_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r   <= SH_IDLE;
      div_r  <= 8'h00;
      cnt_r  <= 5'h00;
      sh_r   <= '0;
      fr_r   <= '0;
      pins_r <= '0;
      rx_r   <= 8'h00;
      done_r <= 1'b0;
      tmo_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      div_r  <= div_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      fr_r   <= fr_nxt;
      pins_r <= pins_nxt;
      rx_r   <= rx_nxt;
      done_r <= done_nxt;
      tmo_r  <= tmo_nxt;
    end
  end

  assign pins_o    = pins_r;
  assign done_o    = done_r;
  assign timeout_o = tmo_r;
  assign polling_o = (st_r == SH_POLL);
  assign rx_o      = rx_r;
endmodule

// ---- design/sec_ctrl.sv ----
// Serial EEPROM command controller with Wishbone register access
module sec_ctrl import sec_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = TMO_CYC
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // EEPROM pins
  output logic             ee_cs_o,
  output logic             ee_sk_o,
  output logic             ee_di_o,
  input  wire logic        ee_do_i,
  // Loaded station address
  output logic [47:0]      mac_addr_o,
  output logic             mac_valid_o
);
  typedef enum logic [1:0] {
    ST_BOOT      = 2'b00,
    ST_BOOT_WAIT = 2'b01,
    ST_IDLE      = 2'b10,
    ST_RUN       = 2'b11
  } sec_state_e;

  function automatic sec_frame_s build_frame(sec_op_e op, logic [6:0] adr, logic [7:0] dat);
    sec_frame_s f;
    f = '0;
    case (op)
      OP_READ:  f = '{tx: {3'b110, adr, 8'h00}, tx_len: 5'd10, rx_len: 4'd8, poll: 1'b0};
      OP_EWDS:  f = '{tx: {3'b100, 7'h00, 8'h00}, tx_len: 5'd10, rx_len: 4'd0, poll: 1'b0};
      OP_EWEN:  f = '{tx: {3'b100, 7'h60, 8'h00}, tx_len: 5'd10, rx_len: 4'd0, poll: 1'b0};
      OP_WRITE: f = '{tx: {3'b101, adr, dat}, tx_len: 5'd18, rx_len: 4'd0, poll: 1'b1};
      OP_WRAL:  f = '{tx: {3'b100, 7'h20, dat}, tx_len: 5'd18, rx_len: 4'd0, poll: 1'b1};
      OP_ERASE: f = '{tx: {3'b111, adr, 8'h00}, tx_len: 5'd10, rx_len: 4'd0, poll: 1'b1};
      OP_ERAL:  f = '{tx: {3'b100, 7'h40, 8'h00}, tx_len: 5'd10, rx_len: 4'd0, poll: 1'b1};
      default:  f = '0;
    endcase
    return f;
  endfunction

  // Pin synchroniser
  logic do_meta_r;
  logic do_sync_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      do_meta_r <= 1'b0;
      do_sync_r <= 1'b0;
    end else begin
      do_meta_r <= ee_do_i;
      do_sync_r <= do_meta_r;
    end
  end

  // Engine and timeout
  logic       start_r, start_nxt;
  sec_frame_s frame_r, frame_nxt;
  sec_pins_s  pins;
  logic       eng_done;
  logic       eng_tmo;
  logic       eng_poll;
  logic       tmr_exp;
  logic [7:0] eng_rx;

  sec_shift u_shift (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .start_i   (start_r),
    .frame_i   (frame_r),
    .abort_i   (tmr_exp),
    .do_i      (do_sync_r),
    .pins_o    (pins),
    .done_o    (eng_done),
    .timeout_o (eng_tmo),
    .polling_o (eng_poll),
    .rx_o      (eng_rx)
  );

  sec_timer #(
    .LIMIT (TIMEOUT_CYC)
  ) u_timer (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .run_i     (eng_poll),
    .expired_o (tmr_exp)
  );

  assign ee_cs_o = pins.cs;
  assign ee_sk_o = pins.sk;
  assign ee_di_o = pins.di;

  // Bus slave: ack one cycle after the request, writes land on the acked edge
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic        req;
  logic        wr_take;

  assign req     = wb_cyc_i && wb_stb_i;
  assign wr_take = req && wb_we_i && ack_r;

  // Control state
  sec_state_e  state_r, state_nxt;
  logic        busy_r, busy_nxt;
  sec_op_e     op_r, op_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic [7:0]  data_r, data_nxt;
  logic        tmo_flag_r, tmo_flag_nxt;
  logic [47:0] mac_r, mac_nxt;
  logic        mac_ok_r, mac_ok_nxt;
  logic [2:0]  idx_r, idx_nxt;
  sec_op_e     wr_op;
  logic [6:0]  wr_addr;

  assign wr_op   = wb_sel_i[3] ? sec_op_e'(wb_dat_i[OP_LSB+:3]) : op_r;
  assign wr_addr = wb_sel_i[0] ? wb_dat_i[ADDR_W-1:0] : addr_r;

  always_comb begin
    ack_nxt  = req && !ack_r;
    rdat_nxt = 32'h0;
    if (ack_nxt && !wb_we_i) begin
      if (wb_adr_i == CMD_OFS) begin
        rdat_nxt = {busy_r, op_r, 21'h0, addr_r};
      end else if (wb_adr_i == DATA_OFS) begin
        rdat_nxt = {24'h0, data_r};
      end else if (wb_adr_i == STAT_OFS) begin
        rdat_nxt[TMO_BIT]   = tmo_flag_r;
        rdat_nxt[MACOK_BIT] = mac_ok_r;
      end else if (wb_adr_i == MACLO_OFS) begin
        rdat_nxt = mac_r[31:0];
      end else if (wb_adr_i == MACHI_OFS) begin
        rdat_nxt = {16'h0, mac_r[47:32]};
      end
    end
  end

  always_comb begin
    state_nxt    = state_r;
    busy_nxt     = busy_r;
    op_nxt       = op_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    tmo_flag_nxt = tmo_flag_r;
    mac_nxt      = mac_r;
    mac_ok_nxt   = mac_ok_r;
    idx_nxt      = idx_r;
    start_nxt    = 1'b0;
    frame_nxt    = frame_r;

    // CMD and DATA writes while busy are dropped so a running frame never changes; the STAT clear still works
    if (wr_take && !busy_r) begin
      if (wb_adr_i == CMD_OFS) begin
        op_nxt   = wr_op;
        addr_nxt = wr_addr;
        if (wb_sel_i[3] && wb_dat_i[BUSY_BIT]) begin
          busy_nxt = 1'b1;
          if (wr_op == OP_RELOAD) begin
            idx_nxt    = 3'h0;
            mac_ok_nxt = 1'b0;
            state_nxt  = ST_BOOT;
          end else begin
            start_nxt = 1'b1;
            frame_nxt = build_frame(wr_op, wr_addr, data_r);
            state_nxt = ST_RUN;
          end
        end
      end else if (wb_adr_i == DATA_OFS && wb_sel_i[0]) begin
        data_nxt = wb_dat_i[7:0];
      end
    end
    if (wr_take && wb_adr_i == STAT_OFS && wb_sel_i[0] && wb_dat_i[TMO_BIT]) begin
      tmo_flag_nxt = 1'b0;
    end

    case (state_r)
      ST_BOOT: begin
        start_nxt = 1'b1;
        frame_nxt = build_frame(OP_READ, {4'h0, idx_r}, 8'h00);
        state_nxt = ST_BOOT_WAIT;
      end
      ST_BOOT_WAIT: begin
        if (eng_done) begin
          if (idx_r == 3'h0 && eng_rx != SIG_BYTE) begin
            // Blank or absent part: give up and leave the address invalid
            busy_nxt  = 1'b0;
            state_nxt = ST_IDLE;
          end else begin
            if (idx_r != 3'h0) begin
              mac_nxt[{idx_r - 3'h1, 3'b000} +: 8] = eng_rx;
            end
            if (idx_r == MAC_BYTES) begin
              mac_ok_nxt = 1'b1;
              busy_nxt   = 1'b0;
              state_nxt  = ST_IDLE;
            end else begin
              idx_nxt   = idx_r + 3'h1;
              state_nxt = ST_BOOT;
            end
          end
        end
      end
      ST_RUN: begin
        if (eng_done) begin
          busy_nxt  = 1'b0;
          state_nxt = ST_IDLE;
          if (op_r == OP_READ) begin
            data_nxt = eng_rx;
          end
          if (eng_tmo) begin
            tmo_flag_nxt = 1'b1;
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r      <= 1'b0;
      rdat_r     <= 32'h0;
      state_r    <= ST_BOOT;
      busy_r     <= BUSY_RST;
      op_r       <= OP_READ;
      addr_r     <= ADDR_RST;
      data_r     <= DATA_RST;
      tmo_flag_r <= 1'b0;
      mac_r      <= 48'h0;
      mac_ok_r   <= 1'b0;
      idx_r      <= 3'h0;
      start_r    <= 1'b0;
      frame_r    <= '0;
    end else begin
      ack_r      <= ack_nxt;
      rdat_r     <= rdat_nxt;
      state_r    <= state_nxt;
      busy_r     <= busy_nxt;
      op_r       <= op_nxt;
      addr_r     <= addr_nxt;
      data_r     <= data_nxt;
      tmo_flag_r <= tmo_flag_nxt;
      mac_r      <= mac_nxt;
      mac_ok_r   <= mac_ok_nxt;
      idx_r      <= idx_nxt;
      start_r    <= start_nxt;
      frame_r    <= frame_nxt;
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdat_r;
  assign mac_addr_o  = mac_r;
  assign mac_valid_o = mac_ok_r;

  // Checks
  chk_boot_busy_held: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_r == ST_BOOT || state_r == ST_BOOT_WAIT) |-> busy_r)
    else $error("busy low during address load");

  chk_cmd_starts_run: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (wr_take && !busy_r && wb_adr_i == CMD_OFS && wb_sel_i[3] && wb_dat_i[BUSY_BIT]
     && wb_dat_i[OP_LSB+:3] != OP_RELOAD) |=> busy_r && start_r ##1 pins.cs)
    else $error("command write did not start a frame");

  chk_read_data_valid: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_r == ST_RUN && eng_done && op_r == OP_READ) |=> !busy_r && data_r == $past(eng_rx))
    else $error("read data not captured at completion");

  chk_busy_until_done: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_r == ST_RUN && !eng_done) |=> busy_r)
    else $error("busy dropped before completion");

  chk_timeout_clears: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_r == ST_RUN && tmr_exp && !do_sync_r) |=> ##1 (!busy_r && tmo_flag_r))
    else $error("timeout did not clear busy");

  chk_boot_ends: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state_r == ST_BOOT_WAIT && eng_done && idx_r == 3'h0 && eng_rx != SIG_BYTE)
    |=> (!busy_r && !mac_ok_r && state_r == ST_IDLE))
    else $error("failed load left busy set");

  chk_busy_locks_cmd: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (busy_r && wr_take) |=> ($stable(op_r) && $stable(addr_r) && (!start_r || $past(state_r) == ST_BOOT)))
    else $error("command changed while busy");

  chk_ack_single: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");

  cov_read_done: cover property (@(posedge clock_i) disable iff (!resetn_i)
    state_r == ST_RUN && eng_done && op_r == OP_READ);
  cov_write_timeout: cover property (@(posedge clock_i) disable iff (!resetn_i)
    state_r == ST_RUN && eng_done && eng_tmo);
  cov_boot_ok: cover property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(mac_ok_r));
endmodule

// ---- dv/sec_eeprom_model.sv ----
// Behavioural three-wire serial EEPROM on the far side of the controller
module sec_eeprom_model (
  // Clock and pins
  input  wire logic clock_i,
  input  wire logic cs_i,
  input  wire logic sk_i,
  input  wire logic di_i,
  // Board option: part fitted
  input  wire logic present_i,
  output logic      do_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:127];
  logic [17:0] sh = '0;
  logic [4:0]  idx = '0;
  logic [7:0]  rsh = '0;
  logic [6:0]  cnt = '0;
  logic        sk_q = 1'b0;
  logic        cs_q = 1'b0;
  logic        do_r = 1'b0;
  logic        ew = 1'b0;
  logic        prog = 1'b0;
  logic        rd = 1'b0;
  logic [9:0]  hdr;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem[0] = 8'ha5;
    for (int i = 1; i < 7; i++) mem[i] = 8'(i * 17);
  end
  // Missing part: board pull-down holds the line low
  assign do_o = present_i ? do_r : 1'b0;
  assign hdr  = (idx == 5'd18) ? sh[17:8] : sh[9:0];
  always @(posedge clock_i) begin
    sk_q <= sk_i;
    cs_q <= cs_i;
    if (cs_i && !cs_q && prog) begin
      cnt  <= 7'd40;
      do_r <= 1'b0;
    end else if (cs_i && prog) begin
      if (cnt != 7'd0) cnt <= cnt - 7'd1;
      do_r <= (cnt == 7'd0);
    end else if (cs_i && sk_i && !sk_q) begin
      sh  <= {sh[16:0], di_i};
      idx <= idx + 5'd1;
      if (idx == 5'd9 && sh[7:6] == 2'b10) begin
        rsh  <= mem[{sh[5:0], di_i}];
        do_r <= mem[{sh[5:0], di_i}][7];
        rd   <= 1'b1;
      end else if (rd && idx < 5'd17) begin
        rsh  <= rsh << 1;
        do_r <= rsh[6];
      end
    end else if (!cs_i && cs_q) begin
      idx <= '0;
      rd  <= 1'b0;
      if (prog) begin
        prog <= 1'b0;
      end else if (idx >= 5'd10 && present_i) begin
        case (hdr[8:7])
          2'b01: begin
            if (ew) mem[hdr[6:0]] <= sh[7:0];
            prog <= 1'b1;
          end
          2'b11: begin
            if (ew) mem[hdr[6:0]] <= 8'hff;
            prog <= 1'b1;
          end
          2'b00: begin
            if (hdr[6:5] == 2'b11) ew <= 1'b1;
            if (hdr[6:5] == 2'b00) ew <= 1'b0;
            if (hdr[6:5] == 2'b01 || hdr[6:5] == 2'b10) begin
              for (int i = 0; i < 128; i++) if (ew) mem[i] <= hdr[6] ? 8'hff : sh[7:0];
              prog <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end else if (!cs_i) begin
      // Released line: changing pattern so no stale bit is trusted
      do_r <= ~do_r;
    end
  end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the serial EEPROM command controller
module tb_top import sec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 200;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  wb_adr = '0;
  logic [31:0] wb_wdat = '0;
  logic [31:0] wb_rdat;
  logic [3:0]  wb_sel = 4'hf;
  logic        wb_we = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_ack;
  logic        ee_cs, ee_sk, ee_di, ee_do;
  logic        present = 1'b1;
  logic [47:0] mac_addr;
  logic        mac_valid;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc_n = 0;

  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) cyc_n <= cyc_n + 1;

  sec_ctrl #(.TIMEOUT_CYC(TMO)) i_sec_ctrl (
    .clock_i(clock_i), .resetn_i(resetn_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .ee_cs_o(ee_cs), .ee_sk_o(ee_sk), .ee_di_o(ee_di), .ee_do_i(ee_do),
    .mac_addr_o(mac_addr), .mac_valid_o(mac_valid));
  sec_eeprom_model i_sec_eeprom_model (
    .clock_i(clock_i), .cs_i(ee_cs), .sk_i(ee_sk), .di_i(ee_di), .present_i(present), .do_o(ee_do));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Classic cycle: ack and read data are taken at the rising edge where ack stands
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    wb_adr <= a;
    wb_we <= we;
    wb_wdat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge clock_i); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(a, 1'b0, 32'h0, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic cmd(input sec_op_e op, input logic [6:0] a);
    wr(CMD_OFS, {1'b1, op, 21'h0, a});
  endtask

  task automatic wait_idle(output int cycles);
    logic [31:0] q;
    int t0;
    t0 = cyc_n;
    do rd(CMD_OFS, q); while (q[BUSY_BIT] !== 1'b0 && cyc_n - t0 < 40000);
    cycles = cyc_n - t0;
    check("busy cleared", 1'b0, q[BUSY_BIT]);
  endtask

  task automatic t_reset_load;
    logic [31:0] q;
    int c;
    rd(CMD_OFS, q);
    check("busy after reset", 1'b1, q[BUSY_BIT]);
    check("mac valid during load", 1'b0, mac_valid);
    wait_idle(c);
    check("mac address", 48'h665544332211, mac_addr);
    check("mac valid", 1'b1, mac_valid);
    rd(MACLO_OFS, q);
    check("mac low word", 32'h44332211, q);
    rd(MACHI_OFS, q);
    check("mac high word", 32'h00006655, q);
    rd(8'h40, q);
    check("unmapped read", 32'h0, q);
  endtask

  task automatic t_write_read;
    logic [31:0] q;
    int c;
    cmd(OP_EWEN, 7'h00);
    wait_idle(c);
    wr(DATA_OFS, 32'h0000003c);
    cmd(OP_WRITE, 7'h7f);
    rd(CMD_OFS, q);
    check("busy during write", 1'b1, q[BUSY_BIT]);
    check("command fields while busy", 32'hb000007f, q);
    wr(STAT_OFS, 32'h1);
    wait_idle(c);
    wr(DATA_OFS, 32'h0);
    cmd(OP_READ, 7'h7f);
    wait_idle(c);
    rd(DATA_OFS, q);
    check("read back byte", 8'h3c, q[7:0]);
  endtask

  task automatic t_timeout;
    logic [31:0] q;
    int c;
    @(posedge clock_i);
    present <= 1'b0;
    cmd(OP_WRITE, 7'h01);
    wait_idle(c);
    check("busy held past timeout", 1'b1, c >= int'(FRAME_W * 2 * SK_HALF_CYC + SK_HALF_CYC + TMO));
    check("busy ends at timeout", 1'b1, c <= int'(FRAME_W * 2 * SK_HALF_CYC + SK_HALF_CYC + TMO + 30));
    rd(STAT_OFS, q);
    check("timeout flag", 1'b1, q[TMO_BIT]);
    wr(STAT_OFS, 32'h1);
    rd(STAT_OFS, q);
    check("timeout flag cleared", 1'b0, q[TMO_BIT]);
    @(posedge clock_i);
    present <= 1'b1;
  endtask

  // Erase-all runs just before the final reload, so the reload finds no signature
  task automatic t_all_ops;
    logic [31:0] q;
    int c;
    for (int k = 0; k < 8; k++) begin
      cmd(sec_op_e'(k), 7'h05);
      wait_idle(c);
      rd(STAT_OFS, q);
      check("no timeout with part fitted", 1'b0, q[TMO_BIT]);
    end
    check("mac valid after failed reload", 1'b0, mac_valid);
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset_load();
    t_write_read();
    t_timeout();
    t_all_ops();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule
